// *** verilog/rtcif_pkg.sv ***
package rtcif_pkg;

  localparam logic [16:0] ADR_FLAGS = 17'h1fff0;
  localparam logic [16:0] ADR_CENT = 17'h1fff1;
  localparam logic [16:0] ADR_AL_SEC = 17'h1fff2;
  localparam logic [16:0] ADR_AL_MIN = 17'h1fff3;
  localparam logic [16:0] ADR_AL_HOUR = 17'h1fff4;
  localparam logic [16:0] ADR_AL_DATE = 17'h1fff5;
  localparam logic [16:0] ADR_IRQCFG = 17'h1fff6;
  localparam logic [16:0] ADR_WDOG = 17'h1fff7;
  localparam logic [16:0] ADR_CAL = 17'h1fff8;
  localparam logic [16:0] ADR_SEC = 17'h1fff9;
  localparam logic [16:0] ADR_MIN = 17'h1fffa;
  localparam logic [16:0] ADR_HOUR = 17'h1fffb;
  localparam logic [16:0] ADR_WDAY = 17'h1fffc;
  localparam logic [16:0] ADR_MDAY = 17'h1fffd;
  localparam logic [16:0] ADR_MONTH = 17'h1fffe;
  localparam logic [16:0] ADR_YEAR = 17'h1ffff;
  localparam logic [12:0] ADR_TOP_PAGE = 13'h1fff;

  // bit positions
  localparam int BIT_TIMEOUT_FLAG = 7;
  localparam int BIT_ALARM_MATCH_FLAG = 6;
  localparam int BIT_SUPPLY_FAIL_FLAG = 5;
  localparam int BIT_OSC_FAILED_FLAG = 4;
  localparam int BIT_TIMEOUT_IRQ_EN = 7;
  localparam int BIT_ALARM_IRQ_EN = 6;
  localparam int BIT_SUPPLY_FAIL_IRQ_EN = 5;
  localparam int BIT_HL = 3;
  localparam int BIT_PL = 2;
  localparam int BIT_TIMEOUT_STROBE = 7;
  localparam int BIT_TIMEOUT_WRITE_LOCK = 6;
  localparam int BIT_MATCH = 7;
  localparam int BIT_OSC_DISABLE = 7;

  // writable masks, fixed-zero bits never stored
  localparam logic [7:0] MASK_IRQCFG = 8'hec;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_MDAY = 8'h3f;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_MINSEC = 8'h7f;
  localparam logic [7:0] MASK_ALDATE = 8'hbf;
  localparam logic [7:0] MASK_CAL = 8'hbf;

  localparam logic [7:0] IRQCFG_RST = 8'h00;
  localparam logic [7:0] IRQCFG_NOBAT = 8'h24;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // timing
  localparam longint CLK_HZ = 10_000_000;
  localparam longint PULSE_MS = 200;
  localparam longint PULSE_CYC = CLK_HZ * PULSE_MS / 1000;
  localparam longint TICK32_HZ = 32;
  localparam longint WD_TICK_CYC = CLK_HZ / TICK32_HZ;
  localparam longint SEC_CYC = CLK_HZ;

  typedef struct packed {
    logic wdog;
    logic alarm;
    logic pfail;
  } rtcif_src_t;

  typedef enum logic [1:0] {
    RTCIF_IDLE = 2'b00,
    RTCIF_ACTIVE = 2'b01,
    RTCIF_DONE = 2'b11
  } rtcif_pin_state_t;

endpackage

// *** verilog/rtcif_core.sv ***
// Contract
// - three sources (watchdog, alarm, supply fail), each with flag and enable
// - pin asserts when any source event occurs while its enable is set
// - flags read clears the three source flags (not oscillator failed), at the end of the read cycle
// - one-shot mode drives a 200 ms pulse per qualified event
// - level mode holds the pin active until the flags register is read
// - config bit 2 picks pulse (1) or level (0)
// - reading flags during a pulse ends the pulse early
// - config bit 7 lets watchdog timeout drive the pin
// - config bit 6 lets alarm match drive the pin
// - config bit 5 lets supply fail drive the pin
// - config bit 3: 1 push-pull active high, 0 open-drain active low
// - on backup power only alarm drives the pin, open-drain low only
// - config resets to 0x00, loads 0x24 on power-on without battery
// - flags in bits 7,6,5 set by their sources, cleared at init
// - on backup power all host reads and writes are refused
// - supply crossing the switch threshold requests a store
// - time registers are BCD with unused bits reading zero
// - four alarm registers each hold BCD value and match bit 7
// - alarm field compared only when its match bit is 0
// - watchdog loads timeout at power up and on strobe; zero sets flag
// - write-lock bit blocks writes to the six-bit timeout field
// - enabled oscillator not running at power up sets failed flag
`timescale 1ns/100ps
`default_nettype none

module rtcif_core
  import rtcif_pkg::*;
#(
  parameter longint PULSE_CYCLES = PULSE_CYC,
  parameter longint WD_TICK_CYCLES = WD_TICK_CYC,
  parameter longint SEC_CYCLES = SEC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic vcc_ok_i,
  input wire logic no_battery_i,
  input wire logic osc_running_i,
  output logic store_req_o,
  output logic int_o,
  output logic int_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  // no reset: the power-on capture must see the real straps on its first edge
  always_ff @(posedge clk_i) begin
    sync1_reg <= {ce_n_i, oe_n_i, we_n_i, vcc_ok_i, no_battery_i, osc_running_i};
    sync2_reg <= sync1_reg;
  end
  logic ce_n, oe_n, we_n, vcc_ok, no_bat, osc_run;
  assign {ce_n, oe_n, we_n, vcc_ok, no_bat, osc_run} = sync2_reg;

  logic [16:0] addr1_reg, addr_reg;
  logic [7:0] din1_reg, din_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr1_reg <= 17'h00000;
      addr_reg <= 17'h00000;
      din1_reg <= 8'h00;
      din_reg <= 8'h00;
    end else begin
      addr1_reg <= addr_i;
      addr_reg <= addr1_reg;
      din1_reg <= dq_i;
      din_reg <= din1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus cycle decode
  logic on_backup;
  assign on_backup = !vcc_ok;
  logic rd_act, wr_act, rd_act_d_reg, wr_act_d_reg;
  assign rd_act = !ce_n && !oe_n && we_n && !on_backup;
  assign wr_act = !ce_n && !we_n && !on_backup;
  logic [16:0] rd_addr_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_act_d_reg <= 1'b0;
      wr_act_d_reg <= 1'b0;
      rd_addr_reg <= 17'h00000;
    end else begin
      rd_act_d_reg <= rd_act;
      wr_act_d_reg <= wr_act;
      if (rd_act) begin
        rd_addr_reg <= addr_reg;
      end
    end
  end
  logic rd_end, wr_end;
  logic [7:0] wdata;
  logic [16:0] waddr;
  assign rd_end = rd_act_d_reg && !rd_act;
  assign wr_end = wr_act_d_reg && !wr_act;
  // read completes with we high; only a finished read clears flags
  logic flag_clr;
  assign flag_clr = rd_end && we_n && (rd_addr_reg == ADR_FLAGS);
  logic [16:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_addr_reg <= 17'h00000;
      wr_data_reg <= 8'h00;
    end else if (wr_act) begin
      wr_addr_reg <= addr_reg;
      wr_data_reg <= din_reg;
    end
  end
  assign waddr = wr_addr_reg;
  assign wdata = wr_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // power-on capture
  logic init_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] cent_reg, al_sec_reg, al_min_reg, al_hour_reg, al_date_reg;
  logic [7:0] cfg_reg, cal_reg, year_reg, month_reg, mday_reg, wday_reg;
  logic [7:0] hour_reg, min_reg, sec_reg;
  logic [5:0] wd_val_reg;
  logic wd_lock_reg, wd_strobe;
  assign wd_strobe = wr_end && (waddr == ADR_WDOG) && wdata[BIT_TIMEOUT_STROBE];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= IRQCFG_RST;
    end else if (init_reg) begin
      cfg_reg <= no_bat ? IRQCFG_NOBAT : IRQCFG_RST;
    end else if (wr_end && waddr == ADR_IRQCFG) begin
      cfg_reg <= wdata & MASK_IRQCFG;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_val_reg <= 6'h00;
      wd_lock_reg <= 1'b0;
    end else if (wr_end && waddr == ADR_WDOG) begin
      wd_lock_reg <= wdata[BIT_TIMEOUT_WRITE_LOCK];
      if (!wdata[BIT_TIMEOUT_WRITE_LOCK] && !wd_lock_reg) begin
        wd_val_reg <= wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cent_reg <= 8'h00;
      al_sec_reg <= 8'h00;
      al_min_reg <= 8'h00;
      al_hour_reg <= 8'h00;
      al_date_reg <= 8'h00;
      cal_reg <= 8'h00;
    end else if (wr_end) begin
      unique case (waddr)
        ADR_CENT: cent_reg <= wdata;
        ADR_AL_SEC: al_sec_reg <= wdata;
        ADR_AL_MIN: al_min_reg <= wdata;
        ADR_AL_HOUR: al_hour_reg <= wdata & MASK_ALDATE;
        ADR_AL_DATE: al_date_reg <= wdata & MASK_ALDATE;
        ADR_CAL: cal_reg <= wdata & MASK_CAL;
        default: cent_reg <= cent_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timekeeping, seconds to years (runs on backup too)
  logic [$clog2(SEC_CYCLES)-1:0] sec_div_reg;
  logic sec_tick;
  assign sec_tick = (sec_div_reg == '0) && osc_run && !cal_reg[BIT_OSC_DISABLE];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || sec_div_reg == '0) begin
      sec_div_reg <= ($clog2(SEC_CYCLES))'(SEC_CYCLES - 1);
    end else begin
      sec_div_reg <= sec_div_reg - 1'b1;
    end
  end

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  logic sec_wrap, min_wrap, hour_wrap, day_wrap, mon_wrap;
  assign sec_wrap = sec_tick && sec_reg == 8'h59;
  assign min_wrap = sec_wrap && min_reg == 8'h59;
  assign hour_wrap = min_wrap && hour_reg == 8'h23;
  assign day_wrap = hour_wrap && mday_reg == 8'h31;
  assign mon_wrap = day_wrap && month_reg == 8'h12;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sec_reg <= 8'h00;
      min_reg <= 8'h00;
      hour_reg <= 8'h00;
      wday_reg <= 8'h01;
      mday_reg <= 8'h01;
      month_reg <= 8'h01;
      year_reg <= 8'h00;
    end else if (wr_end && waddr >= ADR_SEC) begin
      unique case (waddr)
        ADR_SEC: sec_reg <= wdata & MASK_MINSEC;
        ADR_MIN: min_reg <= wdata & MASK_MINSEC;
        ADR_HOUR: hour_reg <= wdata & MASK_HOUR;
        ADR_WDAY: wday_reg <= wdata & MASK_WDAY;
        ADR_MDAY: mday_reg <= wdata & MASK_MDAY;
        ADR_MONTH: month_reg <= wdata & MASK_MONTH;
        default: year_reg <= wdata;
      endcase
    end else if (sec_tick) begin
      sec_reg <= sec_wrap ? 8'h00 : bcd_inc(sec_reg);
      if (sec_wrap) begin
        min_reg <= min_wrap ? 8'h00 : bcd_inc(min_reg);
      end
      if (min_wrap) begin
        hour_reg <= hour_wrap ? 8'h00 : bcd_inc(hour_reg);
      end
      if (hour_wrap) begin
        wday_reg <= (wday_reg == 8'h07) ? 8'h01 : bcd_inc(wday_reg);
        mday_reg <= day_wrap ? 8'h01 : bcd_inc(mday_reg);
      end
      if (day_wrap) begin
        month_reg <= mon_wrap ? 8'h01 : bcd_inc(month_reg);
      end
      if (mon_wrap) begin
        year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm match
  logic alarm_hit;
  assign alarm_hit = sec_tick
    && (al_sec_reg[BIT_MATCH] || al_sec_reg[6:0] == sec_reg[6:0])
    && (al_min_reg[BIT_MATCH] || al_min_reg[6:0] == min_reg[6:0])
    && (al_hour_reg[BIT_MATCH] || al_hour_reg[5:0] == hour_reg[5:0])
    && (al_date_reg[BIT_MATCH] || al_date_reg[5:0] == mday_reg[5:0]);

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  logic [$clog2(WD_TICK_CYCLES)-1:0] wd_div_reg;
  logic [5:0] wd_cnt_reg;
  logic wd_tick, wd_hit;
  assign wd_tick = (wd_div_reg == '0) && osc_run;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wd_div_reg == '0) begin
      wd_div_reg <= ($clog2(WD_TICK_CYCLES))'(WD_TICK_CYCLES - 1);
    end else begin
      wd_div_reg <= wd_div_reg - 1'b1;
    end
  end
  assign wd_hit = wd_tick && wd_cnt_reg == 6'h01;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_cnt_reg <= 6'h00;
    end else if (init_reg || wd_strobe) begin
      wd_cnt_reg <= wd_val_reg;
    end else if (wd_tick && wd_cnt_reg != 6'h00) begin
      wd_cnt_reg <= wd_cnt_reg - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply monitor edge and flags
  logic vcc_ok_d_reg, pfail_hit;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vcc_ok_d_reg <= 1'b1;
    end else begin
      vcc_ok_d_reg <= vcc_ok;
    end
  end
  assign pfail_hit = vcc_ok_d_reg && !vcc_ok;
  assign store_req_o = pfail_hit;

  rtcif_src_t flags_reg, hits, qual;
  logic osc_failed_flag_reg;
  assign hits = '{wdog: wd_hit, alarm: alarm_hit, pfail: pfail_hit};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_reg <= '0;
    end else begin
      // a new event wins over the read clear
      flags_reg <= (flag_clr ? '0 : flags_reg) | hits;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_failed_flag_reg <= 1'b0;
    end else if (init_reg && !cal_reg[BIT_OSC_DISABLE] && !osc_run) begin
      osc_failed_flag_reg <= 1'b1;
    end else if (wr_end && waddr == ADR_FLAGS && !wdata[BIT_OSC_FAILED_FLAG]) begin
      osc_failed_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin driver
  logic pulse_mode, active_high;
  assign pulse_mode = cfg_reg[BIT_PL];
  assign active_high = cfg_reg[BIT_HL];
  always_comb begin
    qual.wdog = hits.wdog && cfg_reg[BIT_TIMEOUT_IRQ_EN];
    qual.alarm = hits.alarm && cfg_reg[BIT_ALARM_IRQ_EN];
    qual.pfail = hits.pfail && cfg_reg[BIT_SUPPLY_FAIL_IRQ_EN];
  end
  logic lvl_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lvl_reg <= 1'b0;
    end else begin
      lvl_reg <= (lvl_reg && !flag_clr) || (|qual);
    end
  end
  logic [$clog2(PULSE_CYCLES + 1)-1:0] pulse_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pulse_cnt_reg <= '0;
    end else if (|qual) begin
      pulse_cnt_reg <= ($clog2(PULSE_CYCLES + 1))'(PULSE_CYCLES);
    end else if (flag_clr) begin
      pulse_cnt_reg <= '0;
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end
  logic pin_active;
  assign pin_active = pulse_mode ? (pulse_cnt_reg != '0) : lvl_reg;
  // push-pull only with main supply; open drain otherwise
  logic pp_mode;
  assign pp_mode = active_high && !on_backup;
  assign int_o = pp_mode ? pin_active : 1'b0;
  // on backup power only an alarm may pull the pin, and only active low
  logic alarm_src_reg, drive_ok;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alarm_src_reg <= 1'b0;
    end else if (qual.alarm) begin
      alarm_src_reg <= 1'b1;
    end else if (flag_clr || !pin_active) begin
      alarm_src_reg <= 1'b0;
    end
  end
  assign drive_ok = !on_backup || (alarm_src_reg && !active_high);
  assign int_oe_o = pp_mode ? 1'b1 : (pin_active && drive_ok);

  ////////////////////////////////////////////////////////////////////////
  // read data
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_reg)
      ADR_FLAGS: rd_mux = {flags_reg, osc_failed_flag_reg, 4'h0};
      ADR_CENT: rd_mux = cent_reg;
      ADR_AL_SEC: rd_mux = al_sec_reg;
      ADR_AL_MIN: rd_mux = al_min_reg;
      ADR_AL_HOUR: rd_mux = al_hour_reg;
      ADR_AL_DATE: rd_mux = al_date_reg;
      ADR_IRQCFG: rd_mux = cfg_reg;
      ADR_WDOG: rd_mux = {1'b0, wd_lock_reg, wd_val_reg};
      ADR_CAL: rd_mux = cal_reg;
      ADR_SEC: rd_mux = sec_reg;
      ADR_MIN: rd_mux = min_reg;
      ADR_HOUR: rd_mux = hour_reg;
      ADR_WDAY: rd_mux = wday_reg;
      ADR_MDAY: rd_mux = mday_reg;
      ADR_MONTH: rd_mux = month_reg;
      ADR_YEAR: rd_mux = year_reg;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
    end else begin
      dq_o <= rd_mux;
      dq_oe_o <= rd_act && (addr_reg[16:4] == ADR_TOP_PAGE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_flag_clear_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_clr && !(|hits) |=> flags_reg == '0) else $error("flags not cleared");
  a_level_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lvl_reg && !flag_clr |=> lvl_reg) else $error("level dropped early");
  a_pulse_starts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    |qual |=> pulse_cnt_reg != '0) else $error("pulse not started");
  a_pulse_ends_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_clr && !(|qual) |=> pulse_cnt_reg == '0) else $error("pulse not cut");
  a_wdog_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wd_hit |=> flags_reg.wdog) else $error("watchdog flag missed");
  a_backup_no_bus: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    on_backup |=> !dq_oe_o) else $error("bus driven on backup");
  a_backup_od: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    on_backup |-> !int_o) else $error("push-pull on backup");
  a_backup_alarm_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    on_backup && !alarm_src_reg |-> !int_oe_o) else $error("non-alarm pin on backup");
  a_cfg_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_reg & ~MASK_IRQCFG) == 8'h00) else $error("fixed bits set");

endmodule

`default_nettype wire

// *** bench/rtcif_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module rtcif_host_model
  import rtcif_pkg::*;
(
  input wire logic clk_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [16:0] addr_o,
  output logic [7:0] dq_o,
  input wire logic [7:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic int_i,
  input wire logic int_oe_i,
  output logic int_line_o
);
  // pull-up on the shared interrupt line
  assign int_line_o = int_oe_i ? int_i : 1'b1;

  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = '0;
    dq_o = '0;
  end

  ////////////////////////////////////////
  // the pin is not used as this host's reset, so flag reads mid-pulse are allowed
  task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i);
    addr_o <= a;
    we_n_o <= 1'b1;
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (dq_oe_i !== 1'b1 && n < 10);
    d = dq_i;
    ok = (dq_oe_i === 1'b1);
    ce_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    addr_o <= ~a;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    dq_o <= d;
    oe_n_o <= 1'b1;
    ce_n_o <= 1'b0;
    we_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_n_o <= 1'b1;
    we_n_o <= 1'b1;
    addr_o <= ~a;
    dq_o <= ~d;
    repeat (5) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import rtcif_pkg::*;
  localparam int PULSE_SIM = 20;
  logic clk_i, rst_n_i, vcc_ok_i, no_battery_i, osc_running_i;
  logic [7:0] dq_o, dq_i, cfg_now, d;
  logic [16:0] addr_i;
  logic dq_oe_o, store_req_o, int_o, int_oe_o, int_line, ce_n_i, oe_n_i, we_n_i, ok;
  int err_total, samples_checked, cycles;

  rtcif_core #(.PULSE_CYCLES(PULSE_SIM), .WD_TICK_CYCLES(8), .SEC_CYCLES(50)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i),
    .addr_i(addr_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .vcc_ok_i(vcc_ok_i),
    .no_battery_i(no_battery_i), .osc_running_i(osc_running_i),
    .store_req_o(store_req_o), .int_o(int_o), .int_oe_o(int_oe_o));

  rtcif_host_model host (
    .clk_i(clk_i), .ce_n_o(ce_n_i), .oe_n_o(oe_n_i), .we_n_o(we_n_i), .addr_o(addr_i),
    .dq_o(dq_i), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .int_i(int_o), .int_oe_i(int_oe_o),
    .int_line_o(int_line));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic pin_on();
    return int_line === cfg_now[BIT_HL];
  endfunction

  task automatic rd_chk(input string what, input logic [16:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    host.rd(a, d, ok);
    cmp_bit({what, " answered"}, 1'b1, ok);
    cmp8(what, exp, d & m);
  endtask

  task automatic set_cfg(input logic [7:0] v);
    host.wr(ADR_IRQCFG, v);
    cfg_now = v;
  endtask

  task automatic wait_pin(input int limit, output logic found);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!pin_on() && n < limit);
    found = pin_on();
  endtask

  task automatic do_reset(input logic nobat);
    rst_n_i <= 1'b0;
    no_battery_i <= nobat;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    do_reset(1'b0);
    rd_chk("cfg after reset", ADR_IRQCFG, 8'hff, IRQCFG_RST);
    rd_chk("flags after reset", ADR_FLAGS, 8'hff, FLAGS_RST);
    do_reset(1'b1);
    rd_chk("cfg no battery", ADR_IRQCFG, 8'hff, IRQCFG_NOBAT);
    set_cfg(8'h00);
    host.wr(ADR_WDOG, 8'h00);
    host.wr(ADR_AL_DATE, 8'h31);
    host.wr(ADR_AL_HOUR, 8'h00);
    host.wr(ADR_AL_MIN, 8'h00);
    host.wr(ADR_AL_SEC, 8'h00);
    host.rd(ADR_FLAGS, d, ok);
    $display("test reset done");
  endtask

  task automatic t_masks();
    host.wr(ADR_IRQCFG, 8'hff);
    rd_chk("cfg fixed zero", ADR_IRQCFG, 8'hff, MASK_IRQCFG);
    host.wr(ADR_WDAY, 8'hff);
    rd_chk("weekday unused bits", ADR_WDAY, 8'hff, MASK_WDAY);
    set_cfg(8'h00);
    host.rd(17'h00000, d, ok);
    cmp_bit("low memory not driven", 1'b0, ok);
    $display("test masks done");
  endtask

  task automatic t_supply();
    logic seen;
    seen = 1'b0;
    set_cfg(8'h20);
    vcc_ok_i <= 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      seen = seen | (store_req_o === 1'b1);
    end
    cmp_bit("store request", 1'b1, seen);
    cmp_bit("supply pin in backup", 1'b0, pin_on());
    host.rd(ADR_FLAGS, d, ok);
    cmp_bit("backup read", 1'b0, ok);
    host.wr(ADR_IRQCFG, 8'hec);
    vcc_ok_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmp_bit("supply fail pin", 1'b1, pin_on());
    rd_chk("cfg kept", ADR_IRQCFG, 8'hff, 8'h20);
    rd_chk("supply flag", ADR_FLAGS, 8'he0, 8'h20);
    cmp_bit("level pin after read", 1'b0, pin_on());
    rd_chk("flags cleared", ADR_FLAGS, 8'he0, 8'h00);
    $display("test supply done");
  endtask

  task automatic t_watchdog();
    int n;
    logic found;
    host.wr(ADR_WDOG, 8'h3f);
    host.wr(ADR_WDOG, 8'hbf);
    set_cfg(8'h8c);
    wait_pin(1200, found);
    cmp_bit("watchdog pulse", 1'b1, found);
    n = 0;
    while (pin_on() && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    cmp_bit("pulse length", 1'b1, n >= PULSE_SIM - 2 && n <= PULSE_SIM + 2);
    host.wr(ADR_WDOG, 8'hbf);
    wait_pin(700, found);
    cmp_bit("watchdog restart", 1'b1, found);
    repeat (2) @(posedge clk_i);
    rd_chk("watchdog flag", ADR_FLAGS, 8'he0, 8'h80);
    cmp_bit("pulse cut by read", 1'b0, pin_on());
    host.wr(ADR_WDOG, 8'h45);
    rd_chk("locked timeout", ADR_WDOG, 8'h3f, 8'h3f);
    host.wr(ADR_WDOG, 8'h05);
    rd_chk("timeout kept while locked", ADR_WDOG, 8'h3f, 8'h3f);
    host.wr(ADR_WDOG, 8'h00);
    set_cfg(8'h00);
    host.rd(ADR_FLAGS, d, ok);
    $display("test watchdog done");
  endtask

  task automatic t_alarm();
    logic found;
    host.wr(ADR_AL_DATE, 8'h80);
    host.wr(ADR_AL_HOUR, 8'h80);
    host.wr(ADR_AL_MIN, 8'h80);
    host.wr(ADR_AL_SEC, 8'h80);
    host.rd(ADR_FLAGS, d, ok);
    repeat (60) @(posedge clk_i);
    cmp_bit("alarm pin disabled", 1'b0, pin_on());
    rd_chk("alarm flag", ADR_FLAGS, 8'h40, 8'h40);
    set_cfg(8'h40);
    wait_pin(120, found);
    cmp_bit("alarm pin", 1'b1, found);
    vcc_ok_i <= 1'b0;
    wait_pin(120, found);
    repeat (4) @(posedge clk_i);
    cmp_bit("alarm pin in backup", 1'b1, int_oe_o === 1'b1 && int_o === 1'b0);
    vcc_ok_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    set_cfg(8'h00);
    host.rd(ADR_FLAGS, d, ok);
    $display("test alarm done");
  endtask

  initial begin
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    cfg_now = 8'h00;
    rst_n_i = 1'b0;
    vcc_ok_i = 1'b1;
    no_battery_i = 1'b0;
    osc_running_i = 1'b1;
    t_reset();
    t_masks();
    t_supply();
    t_watchdog();
    t_alarm();
    close_out();
  end
endmodule

`default_nettype wire
